/* File: design/pts_consts.vh */
// pts_consts.vh: register offsets, field positions, reset values and timing for the timer unit
// assumes: included by bare name from the timer unit and the verification files
`ifndef PTS_CONSTS_VH
`define PTS_CONSTS_VH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define PTS_CLK_PERIOD_NS      10

// ----------------------------------------------------------------
// address map (byte addresses, one 32-bit word per register)
// ----------------------------------------------------------------
`define PTS_ADDR_W             9
`define PTS_OFF_CTRL           6'h00
`define PTS_OFF_XCTRL          6'h04
`define PTS_OFF_XREQ           6'h08
`define PTS_OFF_PERIOD         6'h0C
`define PTS_OFF_CMP1           6'h10
`define PTS_OFF_CMP2           6'h14
`define PTS_OFF_DEADTIME       6'h18
`define PTS_OFF_PLVL           6'h1C
`define PTS_OFF_DITHER         6'h20
`define PTS_OFF_FPSC           6'h24
`define PTS_OFF_STATUS         6'h28
`define PTS_OFF_CLKCTRL        9'h100

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PTS_CTRL_RUN           0
`define PTS_CTRL_CHAIN         1
`define PTS_CTRL_EXT_COUNT_SELECT_LO       2
`define PTS_CTRL_EXT_COUNT_SELECT_HI       3
`define PTS_CTRL_ASYM          4
`define PTS_XREQ_REQ           0
`define PTS_XC_PERIOD          0
`define PTS_XC_CMP1            1
`define PTS_XC_CMP2            2
`define PTS_XC_PLVL            3
`define PTS_XC_DITHER          4
`define PTS_XC_FPSC            5
`define PTS_CLKCTRL_FASTPCLK   0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PTS_RST_CTRL           5'h00
`define PTS_RST_XCTRL          6'h00
`define PTS_RST_PERIOD         16'hFFFF
`define PTS_RST_CMP            16'h0000
`define PTS_RST_DEADTIME       16'h0000

`endif

/* File: design/pts_sync2.v */
// pts_sync2.v: two-flop synchroniser for level inputs arriving from pins
// assumes: inputs are asynchronous to clk; outputs are read by clk logic only
module pts_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);

  reg [W-1:0] stage1Reg;
  reg [W-1:0] stage2Reg;

  // first stage feeds only the second stage
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1Reg <= {W{1'b0}};
      stage2Reg <= {W{1'b0}};
    end else begin
      stage1Reg <= asyncIn;
      stage2Reg <= stage1Reg;
    end
  end

  assign syncOut = stage2Reg;

endmodule

/* File: design/pts_shadow_req.v */
// pts_shadow_req.v: pending shadow transfer request of one timer slice
// assumes: strobes are one-cycle pulses on clk; xferDone is a one-cycle pulse
module pts_shadow_req (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       swReq,
  input  wire [5:0] shadowWr,
  input  wire [5:0] autoEn,
  input  wire       fastPclkSel,
  input  wire       xferDone,
  output reg        pendingReg
);

  wire autoHit;
  wire setReq;
  reg  pendingNext;

  // automatic requests are void while the fast peripheral clock is selected
  assign autoHit = (|(shadowWr & autoEn)) & ~fastPclkSel; // RL4 RL5 RL6 RL7
  assign setReq  = swReq | autoHit; // RL3

  // a request landing in the transfer cycle survives for the next boundary
  always @* begin
    pendingNext = setReq | (pendingReg & ~xferDone); // RL18
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pendingReg <= 1'b0;
    end else begin
      pendingReg <= pendingNext;
    end
  end

endmodule

/* File: design/pts_timer_unit.v */
// pts_timer_unit.v: four 16-bit PWM timer slices with shadow transfer and chaining
// assumes: one clock clk at 100 MHz; the register bus is on clk; external count and
// pattern inputs come from pins and are synchronised here
//
// Functional notes
// RL1: each slice keeps shadow copies; active copies change only on a transfer.
// RL2: transfer moves compare, period and, where present, dead-time values.
// RL3: writing one to the request bit asks for a transfer.
// RL4: with period auto-enable set, a period write asks for a transfer.
// RL5: with compare auto-enables set, compare writes ask for a transfer.
// RL6: passive level, dither and prescaler writes ask when their enables are set.
// RL7: fast peripheral clock selected blocks every automatic request, not software ones.
// RL8: pattern inputs assume bus and module clocks at ratio one to one.
// RL9: asymmetric mode is on when the slice's asym_enable bit is one.
// RL10: asymmetric off: channels independent, each state flag drives a complementary pair.
// RL11: asymmetric on: compare 1 sets, compare 2 clears the first state flag.
// RL12: asymmetric on: second state flag is never updated.
// RL13: four 16-bit timers chain into 32, 48 or 64 bit counters.
// RL14: a slice joins the chain when its chain_enable bit is one.
// RL15: selected external count makes the timer step on each input rising edge.
// RL16: a non-zero ext_count_select code turns chaining off.
// RL17: each lower-timer wrap steps the next chained timer once.
// RL18: pending transfer happens at the next period boundary, then clears; here a stopped timer transfers at once instead.
// RL19: dead-time shadow and transfer exist only in the two-channel variant.
//
// The plain strobed port and the register offsets were decided locally.
`include "pts_consts.vh"
module pts_timer_unit #(
  parameter TWO_CHANNEL = 1,
  parameter TIMER_W     = 16,
  parameter DT_W        = 8
) (
  input  wire                    clk,
  input  wire                    rst_b,
  input  wire [`PTS_ADDR_W-1:0]  regAddr,
  input  wire [31:0]             regWrData,
  input  wire                    regWr,
  input  wire                    regRd,
  output reg  [31:0]             regRdData,
  input  wire [2:0]              extCountIn,
  input  wire [3:0]              multichannelPatternIn,
  output reg  [7:0]              pwmHigh,
  output reg  [7:0]              pwmLow
);

  // address width in the port list needs the constants ahead of the header
  localparam NUM_SLICES = 4;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // picks one of the three external count lines by a non-zero select code
  function extPick;
    input [2:0] lines;
    input [1:0] sel;
    begin
      case (sel)
        2'h1:    extPick = lines[0];
        2'h2:    extPick = lines[1];
        2'h3:    extPick = lines[2];
        default: extPick = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // unit-wide state
  // ----------------------------------------------------------------
  wire [2:0]                extSync;
  reg  [2:0]                extPrevReg;
  wire [3:0]                patternSync;
  reg                       fastPclkReg;
  wire                      selGlobal;
  wire [NUM_SLICES-1:0]     sliceWrap;
  wire [NUM_SLICES:0]       wrapChainIn;
  wire [32*NUM_SLICES-1:0]  sliceRdData;
  wire [7:0]                pwmHighNext;
  wire [7:0]                pwmLowNext;
  wire [1:0]                rdSlice;

  pts_sync2 #(
    .W (3)
  ) uExtSync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn (extCountIn),
    .syncOut (extSync)
  );

  // sampled on the module clock; a different bus clock ratio would break this
  pts_sync2 #(
    .W (4)
  ) uPatSync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn (multichannelPatternIn),
    .syncOut (patternSync)
  ); // RL8

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extPrevReg <= 3'h0;
    end else begin
      extPrevReg <= extSync;
    end
  end

  assign selGlobal   = (regAddr == `PTS_OFF_CLKCTRL);
  assign wrapChainIn = {sliceWrap, 1'b0};
  assign rdSlice     = regAddr[7:6];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fastPclkReg <= 1'b0;
    end else if (regWr && selGlobal) begin
      fastPclkReg <= regWrData[`PTS_CLKCTRL_FASTPCLK];
    end
  end

  // ----------------------------------------------------------------
  // timer slices
  // ----------------------------------------------------------------
  genvar gi;
  genvar gc;
  generate
    for (gi = 0; gi < NUM_SLICES; gi = gi + 1) begin : gSlice
      reg  [4:0]          ctrlReg;
      reg  [5:0]          xctrlReg;
      reg  [TIMER_W-1:0]  counterReg;
      reg  [TIMER_W-1:0]  perShReg;
      reg  [TIMER_W-1:0]  perReg;
      reg  [TIMER_W-1:0]  cmp1ShReg;
      reg  [TIMER_W-1:0]  cmp1Reg;
      reg  [TIMER_W-1:0]  cmp2ShReg;
      reg  [TIMER_W-1:0]  cmp2Reg;
      reg  [2*DT_W-1:0]   dtShReg;
      reg  [2*DT_W-1:0]   dtReg;
      reg  [1:0]          plvlShReg;
      reg  [1:0]          plvlReg;
      reg  [3:0]          dithShReg;
      reg  [3:0]          dithReg;
      reg  [3:0]          fpscShReg;
      reg  [3:0]          fpscReg;
      reg  [3:0]          pscCntReg;
      reg                 st1Reg;
      reg                 st2Reg;
      reg  [31:0]         rdMux;
      wire                selSlice;
      wire [5:0]          off;
      wire                wrCtrl;
      wire                wrXctrl;
      wire                wrXreq;
      wire [5:0]          shadowWr;
      wire                pending;
      wire                run;
      wire [1:0]          ext_count_select;
      wire                asym;
      wire                chainOn;
      wire                pscTick;
      wire                extEdge;
      wire                countEn;
      wire                atPeriod;
      wire                wrap;
      wire                boundary;
      wire                doXfer;
      wire [TIMER_W-1:0]  cntNext;

      assign selSlice = ~regAddr[8] && (regAddr[7:6] == gi);
      assign off      = regAddr[5:0];
      assign wrCtrl   = regWr && selSlice && (off == `PTS_OFF_CTRL);
      assign wrXctrl  = regWr && selSlice && (off == `PTS_OFF_XCTRL);
      assign wrXreq   = regWr && selSlice && (off == `PTS_OFF_XREQ)
                        && regWrData[`PTS_XREQ_REQ]; // RL3
      assign shadowWr[`PTS_XC_PERIOD] = regWr && selSlice && (off == `PTS_OFF_PERIOD);
      assign shadowWr[`PTS_XC_CMP1]   = regWr && selSlice && (off == `PTS_OFF_CMP1);
      assign shadowWr[`PTS_XC_CMP2]   = regWr && selSlice && (off == `PTS_OFF_CMP2)
                                        && (TWO_CHANNEL != 0);
      assign shadowWr[`PTS_XC_PLVL]   = regWr && selSlice && (off == `PTS_OFF_PLVL);
      assign shadowWr[`PTS_XC_DITHER] = regWr && selSlice && (off == `PTS_OFF_DITHER);
      assign shadowWr[`PTS_XC_FPSC]   = regWr && selSlice && (off == `PTS_OFF_FPSC);

      assign run  = ctrlReg[`PTS_CTRL_RUN];
      assign ext_count_select = ctrlReg[`PTS_CTRL_EXT_COUNT_SELECT_HI:`PTS_CTRL_EXT_COUNT_SELECT_LO];
      assign asym = ctrlReg[`PTS_CTRL_ASYM] && (TWO_CHANNEL != 0); // RL9

      // -- clock sources --
      // external counting and chaining are exclusive; external wins
      assign chainOn  = ctrlReg[`PTS_CTRL_CHAIN] && (ext_count_select == 2'h0) && (gi != 0); // RL14 RL16
      assign pscTick  = run && (pscCntReg == fpscReg);
      assign extEdge  = extPick(extSync, ext_count_select) && !extPick(extPrevReg, ext_count_select); // RL15
      assign countEn  = run && ((ext_count_select != 2'h0) ? extEdge :
                                chainOn ? wrapChainIn[gi] : pscTick); // RL15 RL17
      assign atPeriod = (counterReg == perReg);
      assign wrap     = countEn && atPeriod;
      assign sliceWrap[gi] = wrap; // RL13 RL17
      assign cntNext  = wrap ? {TIMER_W{1'b0}} :
                        countEn ? counterReg + 1'b1 : counterReg;

      // a stopped timer has no boundary to wait for, so it transfers at once
      assign boundary = wrap || !run; // RL18
      assign doXfer   = pending && boundary;

      pts_shadow_req uReq (
        .clk         (clk),
        .rst_b       (rst_b),
        .swReq       (wrXreq),
        .shadowWr    (shadowWr),
        .autoEn      (xctrlReg),
        .fastPclkSel (fastPclkReg),
        .xferDone    (doXfer),
        .pendingReg  (pending)
      ); // RL3 RL4 RL5 RL6 RL7

      // -- control and shadow registers --
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          ctrlReg   <= `PTS_RST_CTRL;
          xctrlReg  <= `PTS_RST_XCTRL;
          perShReg  <= `PTS_RST_PERIOD;
          cmp1ShReg <= `PTS_RST_CMP;
          cmp2ShReg <= `PTS_RST_CMP;
          dtShReg   <= `PTS_RST_DEADTIME;
          plvlShReg <= 2'h0;
          dithShReg <= 4'h0;
          fpscShReg <= 4'h0;
        end else begin
          if (wrCtrl) begin
            ctrlReg <= regWrData[4:0];
          end
          if (wrXctrl) begin
            xctrlReg <= regWrData[5:0];
          end
          if (shadowWr[`PTS_XC_PERIOD]) begin
            perShReg <= regWrData[TIMER_W-1:0]; // RL1
          end
          if (shadowWr[`PTS_XC_CMP1]) begin
            cmp1ShReg <= regWrData[TIMER_W-1:0];
          end
          if (shadowWr[`PTS_XC_CMP2]) begin
            cmp2ShReg <= regWrData[TIMER_W-1:0];
          end
          if (regWr && selSlice && (off == `PTS_OFF_DEADTIME) && (TWO_CHANNEL != 0)) begin
            dtShReg <= regWrData[2*DT_W-1:0]; // RL19
          end
          if (shadowWr[`PTS_XC_PLVL]) begin
            plvlShReg <= regWrData[1:0];
          end
          if (shadowWr[`PTS_XC_DITHER]) begin
            dithShReg <= regWrData[3:0];
          end
          if (shadowWr[`PTS_XC_FPSC]) begin
            fpscShReg <= regWrData[3:0];
          end
        end
      end

      // -- active copies, loaded only by a transfer --
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          perReg  <= `PTS_RST_PERIOD;
          cmp1Reg <= `PTS_RST_CMP;
          cmp2Reg <= `PTS_RST_CMP;
          dtReg   <= `PTS_RST_DEADTIME;
          plvlReg <= 2'h0;
          dithReg <= 4'h0;
          fpscReg <= 4'h0;
        end else if (doXfer) begin
          perReg  <= perShReg; // RL1 RL2
          cmp1Reg <= cmp1ShReg; // RL2
          cmp2Reg <= cmp2ShReg; // RL2
          if (TWO_CHANNEL != 0) begin
            dtReg <= dtShReg; // RL2 RL19
          end
          plvlReg <= plvlShReg;
          dithReg <= dithShReg;
          fpscReg <= fpscShReg;
        end
      end

      // -- counter and prescaler --
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          counterReg <= {TIMER_W{1'b0}};
          pscCntReg  <= 4'h0;
        end else begin
          counterReg <= cntNext;
          if (!run || pscTick) begin
            pscCntReg <= 4'h0;
          end else begin
            pscCntReg <= pscCntReg + 4'h1;
          end
        end
      end

      // -- compare state flags --
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          st1Reg <= 1'b0;
          st2Reg <= 1'b0;
        end else if (countEn) begin
          if (asym) begin
            if (cntNext == cmp1Reg) begin
              st1Reg <= 1'b1; // RL11
            end else if (cntNext == cmp2Reg) begin
              st1Reg <= 1'b0; // RL11
            end
            // second flag frozen in this mode, so channel 2 holds its last level
            st2Reg <= st2Reg; // RL12
          end else begin
            st1Reg <= (cntNext >= cmp1Reg); // RL10
            st2Reg <= (cntNext >= cmp2Reg) && (TWO_CHANNEL != 0); // RL10
          end
        end
      end

      // -- complementary outputs with dead time --
      for (gc = 0; gc < 2; gc = gc + 1) begin : gChan
        reg  [DT_W-1:0] dtCntReg;
        reg             stPrevReg;
        wire            st;
        wire            dtIdle;
        wire            hiAct;
        wire            loAct;

        assign st     = (gc == 0) ? st1Reg : st2Reg;
        assign dtIdle = (dtCntReg == {DT_W{1'b0}});

        always @(posedge clk or negedge rst_b) begin
          if (!rst_b) begin
            dtCntReg  <= {DT_W{1'b0}};
            stPrevReg <= 1'b0;
          end else begin
            stPrevReg <= st;
            if (st && !stPrevReg) begin
              dtCntReg <= dtReg[DT_W-1:0];
            end else if (!st && stPrevReg) begin
              dtCntReg <= dtReg[2*DT_W-1:DT_W];
            end else if (!dtIdle) begin
              dtCntReg <= dtCntReg - 1'b1;
            end
          end
        end

        // pattern low forces the passive level on both lines of the pair
        assign hiAct = st && dtIdle && patternSync[gi]; // RL10 RL11
        assign loAct = !st && dtIdle && patternSync[gi];
        assign pwmHighNext[2*gi+gc] = hiAct ^ plvlReg[gc];
        assign pwmLowNext[2*gi+gc]  = loAct ^ plvlReg[gc];
      end

      // -- read mux --
      always @* begin
        rdMux = 32'h0000_0000;
        case (off)
          `PTS_OFF_CTRL:     rdMux[4:0] = ctrlReg;
          `PTS_OFF_XCTRL:    rdMux[5:0] = xctrlReg;
          `PTS_OFF_XREQ:     rdMux[`PTS_XREQ_REQ] = pending;
          `PTS_OFF_PERIOD:   rdMux = {perReg, perShReg};
          `PTS_OFF_CMP1:     rdMux = {cmp1Reg, cmp1ShReg};
          `PTS_OFF_CMP2:     rdMux = {cmp2Reg, cmp2ShReg};
          `PTS_OFF_DEADTIME: rdMux = {dtReg, dtShReg};
          `PTS_OFF_PLVL:     rdMux = {14'h0000, plvlReg, 14'h0000, plvlShReg};
          `PTS_OFF_DITHER:   rdMux = {12'h000, dithReg, 12'h000, dithShReg};
          `PTS_OFF_FPSC:     rdMux = {12'h000, fpscReg, 12'h000, fpscShReg};
          `PTS_OFF_STATUS:   rdMux = {counterReg, 14'h0000, st2Reg, st1Reg};
          default:           rdMux = 32'h0000_0000;
        endcase
      end

      assign sliceRdData[32*gi +: 32] = rdMux;
    end
  endgenerate

  // ----------------------------------------------------------------
  // output and read-data registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwmHigh <= 8'h00;
      pwmLow  <= 8'h00;
    end else begin
      pwmHigh <= pwmHighNext;
      pwmLow  <= pwmLowNext;
    end
  end

  // unmapped reads return zero; data stands only in the cycle after the strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 32'h0000_0000;
    end else if (regRd) begin
      if (selGlobal) begin
        regRdData <= {31'h0000_0000, fastPclkReg};
      end else if (!regAddr[8]) begin
        regRdData <= sliceRdData[32*rdSlice +: 32];
      end else begin
        regRdData <= 32'h0000_0000;
      end
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

endmodule

/* File: verification/pts_unit_assertions.sv */
// pts_unit_assertions.sv: port-level checks of the four-slice timer unit
// assumes: bound to pts_timer_unit; one clock clk, asynchronous reset rst_b
`include "pts_consts.vh"
module pts_unit_assertions (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic [`PTS_ADDR_W-1:0] regAddr,
  input wire logic [31:0]            regWrData,
  input wire logic                   regWr,
  input wire logic                   regRd,
  input wire logic [31:0]            regRdData,
  input wire logic [2:0]             extCountIn,
  input wire logic [3:0]             multichannelPatternIn,
  input wire logic [7:0]             pwmHigh,
  input wire logic [7:0]             pwmLow
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_rd_idle_zero: assert property (!regRd |=> regRdData == 32'h0)
    else $error("read data not zero outside its slot");
  chk_unmapped_slice: assert property (regRd && regAddr == 9'h02C |=> regRdData == 32'h0)
    else $error("unmapped slice read not zero");
  chk_unmapped_top: assert property (regRd && regAddr == 9'h104 |=> regRdData == 32'h0)
    else $error("unmapped top read not zero");
  chk_req_pending: assert property (regWr && regAddr == 9'h008 && regWrData[0] ##1
    regRd && regAddr == 9'h008 |=> regRdData[0]) else $error("request not pending");
  chk_ctrl_readback: assert property (regWr && regAddr == 9'h040 ##1
    regRd && regAddr == 9'h040 |=> regRdData[4:0] == $past(regWrData[4:0], 2))
    else $error("control fields not kept");
  chk_gate_slice0: assert property ((!multichannelPatternIn[0]) [*4] |->
    pwmHigh[1:0] == pwmLow[1:0]) else $error("slice 0 not parked when gated");
  chk_gate_slice3: assert property ((!multichannelPatternIn[3]) [*4] |->
    pwmHigh[7:6] == pwmLow[7:6]) else $error("slice 3 not parked when gated");
  chk_reset_quiet: assert property ($rose(rst_b) |-> pwmHigh == 8'h00 && pwmLow == 8'h00)
    else $error("outputs active right after reset");
endmodule
bind pts_timer_unit pts_unit_assertions pts_unit_assertions_i (.clk(clk), .rst_b(rst_b),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .extCountIn(extCountIn),
  .multichannelPatternIn(multichannelPatternIn), .pwmHigh(pwmHigh), .pwmLow(pwmLow));

/* File: verification/pts_power_stage.sv */
// pts_power_stage.sv: behavioural bridge driver fed by the PWM line pairs
// assumes: lines registered on clk; passive level zero while armed
module pts_power_stage (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       armed,
  input  wire logic [7:0] pwmHigh,
  input  wire logic [7:0] pwmLow,
  output logic            faultSeen
);
  timeunit 1ns;
  timeprecision 1ps;
  // sampled on the unit clock: pattern and bus clocks kept at ratio one
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      faultSeen <= 1'b0;
    else if (armed && |(pwmHigh & pwmLow))
      faultSeen <= 1'b1; // both switches on would short the bridge
  end
endmodule

/* File: verification/pts_timer_unit_tb_top.sv */
// pts_timer_unit_tb_top.sv: register-level tests of the timer unit
// assumes: design, checker and power stage model compiled first
`include "pts_consts.vh"
module pts_timer_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, regWr, regRd, armed, faultSeen;
  logic [8:0]  regAddr;
  logic [31:0] regWrData, regRdData, d, c0;
  logic [2:0]  extCountIn;
  logic [3:0]  multichannelPatternIn;
  logic [7:0]  pwmHigh, pwmLow;
  int          err_count, n_compared, cycles, h1, h2;
  logic [8:0]  offs [6] = '{9'h00C, 9'h010, 9'h014, 9'h01C, 9'h020, 9'h024};
  logic [15:0] vals [6] = '{16'h0010, 16'h0004, 16'h000C, 16'h0002, 16'h0005, 16'h0001};
  pts_timer_unit pts_timer_unit_i (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .extCountIn(extCountIn), .multichannelPatternIn(multichannelPatternIn),
    .pwmHigh(pwmHigh), .pwmLow(pwmLow));
  pts_power_stage pts_power_stage_i (.clk(clk), .rst_b(rst_b), .armed(armed),
    .pwmHigh(pwmHigh), .pwmLow(pwmLow), .faultSeen(faultSeen));
  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    regWr <= 1'b1;
    regRd <= 1'b0;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk);
  endtask
  task automatic rd(input logic [8:0] a, output logic [31:0] v);
    regRd <= 1'b1;
    regWr <= 1'b0;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdData;
    @(posedge clk);
  endtask
  task automatic tick(input int n);
    regWr <= 1'b0;
    regRd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic meas(input int n);
    h1 = 0;
    h2 = 0;
    repeat (n) begin
      @(negedge clk);
      h1 += pwmHigh[0];
      h2 += pwmHigh[1];
    end
    @(posedge clk);
  endtask
  task automatic pulses(input int ln);
    repeat (5) begin
      extCountIn[ln] <= 1'b1;
      tick(3);
      extCountIn[ln] <= 1'b0;
      tick(3);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish;
    end
  end
  initial begin
    {rst_b, regWr, regRd, armed, regAddr, regWrData, extCountIn} = '0;
    multichannelPatternIn = 4'h7; // slice 3 stays gated all run
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    wr(9'h010, 32'h1234);
    rd(9'h010, d); chk("cmp1 shadow only", 32'h00001234, d);
    wr(9'h008, 32'h1);
    rd(9'h008, d); chk("request pending", 32'h1, d);
    tick(2);
    rd(9'h008, d); chk("request cleared", 32'h0, d);
    rd(9'h010, d); chk("cmp1 moved", 32'h12341234, d);
    for (int i = 0; i < 6; i++) begin
      wr(9'h004, 32'h1 << i);
      wr(offs[i], {16'h0, vals[i]});
      tick(3);
      rd(offs[i], d); chk("auto transfer", {vals[i], vals[i]}, d);
    end
    wr(9'h004, 32'h0);
    wr(9'h018, 32'h0302);
    wr(9'h008, 32'h1);
    tick(3);
    rd(9'h018, d); chk("dead time", 32'h03020302, d);
    wr(9'h018, 32'h0);
    wr(9'h01C, 32'h0);
    wr(9'h008, 32'h1);
    wr(9'h100, 32'h1);
    wr(9'h004, 32'h3F);
    wr(9'h010, 32'h8);
    tick(3);
    rd(9'h010, d); chk("auto blocked", 32'h00040008, d);
    wr(9'h008, 32'h1);
    tick(3);
    rd(9'h010, d); chk("software still", 32'h00080008, d);
    wr(9'h100, 32'h0);
    rd(9'h02C, d); chk("unmapped slice", 32'h0, d);
    rd(9'h104, d); chk("unmapped top", 32'h0, d);
    // period 16, prescaler 2: one period is 34 clocks, so 68 gives exact duty counts
    armed <= 1'b1;
    wr(9'h000, 32'h1);
    tick(40);
    meas(68);
    chk("ch1 duty", 36, h1);
    chk("ch2 duty", 20, h2);
    wr(9'h000, 32'h11);
    tick(40);
    meas(68);
    chk("asym ch1 duty", 16, h1);
    chk("asym ch2 steady", 1, h2 == 0 || h2 == 68);
    multichannelPatternIn <= 4'h6;
    tick(5);
    @(negedge clk) chk("gated pair", 32'h0, {pwmHigh[1:0], pwmLow[1:0]});
    @(posedge clk);
    multichannelPatternIn <= 4'h7;
    tick(1);
    for (int s = 1; s < 4; s++) begin
      wr(9'h040, (s << 2) | 3);
      rd(9'h040, d); chk("ctrl fields", (s << 2) | 3, d[4:0]);
      pulses(s - 1);
      tick(5);
      rd(9'h068, d); chk("external count", 5 * s, d[31:16]);
    end
    wr(9'h040, 32'h3);
    rd(9'h068, c0);
    tick(338);
    rd(9'h068, d); chk("chained steps", 10, d[31:16] - c0[31:16]);
    chk("bridge short", 32'h0, faultSeen);
    tally_and_finish;
  end
endmodule
